/* File: hdl/uartc_top.v */
// Purpose: Control and status of a UART: enables, flow, errors, break, pins
// Assumes: Serial engine outside drives the rx and tx status inputs
// Notes: APB slave, one wait state on every access
`timescale 1ns/100ps
`include "uartc_regs.vh"

module uartc_top #(
    parameter MS_CYCLES = `UARTC_MS_CYCLES
) (
    input wire clock,
    input wire reset_n,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [13:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // OTP shadow loading and class command
    input wire otp_wr_valid,
    input wire [1:0] otp_wr_sel,
    input wire [11:0] otp_wr_data,
    input wire class_cmd,
    // Serial engine status
    input wire bit_tick,
    input wire tx_busy,
    input wire rx_byte_valid,
    input wire [7:0] rx_byte,
    input wire rx_frame_err,
    input wire rx_parity_err,
    input wire rx_fifo_full,
    input wire rx_break_level,
    input wire addr_matched,
    // Controls to the serial engine
    output reg tx_permit,
    output reg rx_accept,
    output reg tx_break,
    // Pins
    input wire [5:0] pin_in,
    output reg [5:0] pin_out,
    output reg [5:0] pin_oe
);

    // =====================================================
    // Transceiver state encoding
    localparam XC_IDLE = 3'b001;
    localparam XC_DRIVE = 3'b010;
    localparam XC_HOLD = 3'b100;
    // Divider is 16 bits; cut the parameter arithmetic on purpose
    localparam [31:0] MS_WIDE = MS_CYCLES - 1;
    localparam [15:0] MS_LAST = MS_WIDE[15:0];

    // =====================================================
    // Registers
    reg [11:0] sh_func_reg;
    reg [11:0] sh_dir_reg;
    reg [11:0] sh_mask_reg;
    reg [1:0] enable_reg;
    reg [3:0] flow_reg;
    reg [7:0] resume_reg;
    reg [7:0] pause_reg;
    reg [3:0] err_reg;
    reg [11:0] break_reg;
    reg [3:0] delay_reg;
    reg [3:0] pin_func_reg;
    reg [5:0] pin_dir_reg;
    reg [5:0] pin_mask_reg;
    reg paused_reg;
    reg brk_live_reg;
    reg [15:0] ms_cnt_reg;
    reg [2:0] xc_state_reg;
    reg [3:0] turn_cnt_reg;

    // =====================================================
    // Bus decode
    wire [11:0] idx = paddr[13:2];
    wire acc = psel && penable;
    wire done = acc && pready;
    wire wr_done = done && pwrite;
    wire rd_err = done && !pwrite && (idx == `UARTC_IDX_ERROR);
    reg mapped;
    reg [31:0] rd_val;

    // Read mux; reserved bits read zero
    always @*
    begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        case (idx)
            `UARTC_IDX_SH_FUNC: rd_val[11:0] = sh_func_reg;
            `UARTC_IDX_SH_DIR: rd_val[11:0] = sh_dir_reg;
            `UARTC_IDX_SH_MASK: rd_val[11:0] = sh_mask_reg;
            `UARTC_IDX_ENABLE: rd_val[1:0] = enable_reg;
            `UARTC_IDX_FLOW: rd_val[3:0] = flow_reg;
            `UARTC_IDX_RESUME: rd_val[7:0] = resume_reg;
            `UARTC_IDX_PAUSE: rd_val[7:0] = pause_reg;
            `UARTC_IDX_ERROR: rd_val[7:3] = {brk_live_reg, err_reg};
            `UARTC_IDX_BREAK: rd_val[11:0] = break_reg;
            `UARTC_IDX_DELAY: rd_val[3:0] = delay_reg;
            `UARTC_IDX_PIN_FUNC: rd_val[3:0] = pin_func_reg;
            `UARTC_IDX_PIN_DIR: rd_val[5:0] = pin_dir_reg;
            `UARTC_IDX_PIN_MASK: rd_val[5:0] = pin_mask_reg;
            default: mapped = 1'b0;
        endcase
    end

    // One wait state, then answer with data or error
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= acc && !pready;
            pslverr <= acc && !pready && !mapped;
            if (acc && !pready)
                prdata <= pwrite ? 32'h0000_0000 : rd_val;
        end
    end

    // =====================================================
    // Shadow registers: OTP port only, bus writes ignored
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sh_func_reg <= `UARTC_RST_ZERO12;
            sh_dir_reg <= `UARTC_RST_ZERO12;
            sh_mask_reg <= `UARTC_RST_ZERO12;
        end
        else if (otp_wr_valid)
        begin
            case (otp_wr_sel)
                `UARTC_OTP_FUNC: sh_func_reg <= otp_wr_data;
                `UARTC_OTP_DIR: sh_dir_reg <= otp_wr_data;
                `UARTC_OTP_MASK: sh_mask_reg <= otp_wr_data;
                default: sh_func_reg <= sh_func_reg;
            endcase
        end
    end

    // =====================================================
    // Working configuration registers
    // Host keeps UART disabled while writing these; no guard here
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            enable_reg <= 2'b00;
            flow_reg <= 4'h0;
            resume_reg <= `UARTC_RST_RESUME;
            pause_reg <= `UARTC_RST_PAUSE;
            delay_reg <= 4'h0;
            pin_func_reg <= 4'h0;
            pin_dir_reg <= 6'h00;
            pin_mask_reg <= 6'h00;
        end
        else
        begin
            if (wr_done)
            begin
                case (idx)
                    `UARTC_IDX_ENABLE: enable_reg <= pwdata[1:0];
                    `UARTC_IDX_FLOW: flow_reg <= pwdata[3:0];
                    `UARTC_IDX_RESUME: resume_reg <= pwdata[7:0];
                    `UARTC_IDX_PAUSE: pause_reg <= pwdata[7:0];
                    `UARTC_IDX_DELAY: delay_reg <= pwdata[3:0];
                    `UARTC_IDX_PIN_FUNC: pin_func_reg <= pwdata[3:0];
                    `UARTC_IDX_PIN_DIR: pin_dir_reg <= pwdata[5:0];
                    `UARTC_IDX_PIN_MASK: pin_mask_reg <= pwdata[5:0];
                    default: enable_reg <= enable_reg;
                endcase
            end
            // Class command wins over a bus write in the same cycle
            if (class_cmd)
            begin
                pin_func_reg <= sh_func_reg[3:0];
                pin_dir_reg <= sh_dir_reg[5:0];
                pin_mask_reg <= sh_mask_reg[5:0];
            end
        end
    end

    // =====================================================
    // Mode decode
    wire [2:0] fmode = flow_reg[2:0];
    wire [2:0] pmode = pin_func_reg[2:0];
    wire tx_on = enable_reg[`UARTC_EN_TX];
    wire rx_on = enable_reg[`UARTC_EN_RX];
    wire hdx = flow_reg[`UARTC_FLOW_HDX];
    wire xc_active = (xc_state_reg != XC_IDLE);
    // Receive discarded while sending in half-duplex
    wire rx_gate = rx_on && !(hdx && (tx_busy || xc_active))
        && !(fmode == `UARTC_FLOW_MD_RX && !addr_matched)
        && !(fmode == `UARTC_FLOW_MD_ALL && !addr_matched);
    wire rx_take = rx_byte_valid && rx_gate;
    wire cts_ok = (pmode == `UARTC_PF_RTSCTS) ? !pin_in[`UARTC_PIN_FOUR] :
        (pmode == `UARTC_PF_DTRDSR) ? !pin_in[`UARTC_PIN_TWO] : 1'b1;
    wire brk_req = (break_reg != `UARTC_BRK_ZERO);

    // =====================================================
    // Software flow: pause and resume characters
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            paused_reg <= 1'b0;
        else if (fmode != `UARTC_FLOW_SW)
            paused_reg <= 1'b0;
        else if (rx_take && rx_byte == pause_reg)
            paused_reg <= 1'b1;
        else if (rx_take && rx_byte == resume_reg)
            paused_reg <= 1'b0;
    end

    // =====================================================
    // Error flags; a new event wins over the read clear
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            err_reg <= 4'h0;
            brk_live_reg <= 1'b0;
        end
        else
        begin
            brk_live_reg <= rx_break_level;
            err_reg <= (rd_err ? 4'h0 : err_reg) | {
                rx_take && rx_fifo_full,
                rx_take && rx_parity_err,
                rx_take && rx_frame_err,
                rx_on && rx_break_level && !brk_live_reg};
        end
    end

    // =====================================================
    // Millisecond divider and break counter
    // Divider free-runs, so onset of counting may lag up to 1 ms
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            ms_cnt_reg <= 16'h0000;
        else if (ms_cnt_reg == MS_LAST)
            ms_cnt_reg <= 16'h0000;
        else
            ms_cnt_reg <= ms_cnt_reg + 16'h0001;
    end
    wire ms_tick = (ms_cnt_reg == MS_LAST);

    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            break_reg <= `UARTC_BRK_ZERO;
        else if (wr_done && idx == `UARTC_IDX_BREAK)
            break_reg <= pwdata[11:0];
        else if (ms_tick && brk_req && break_reg != `UARTC_BRK_HOLD)
            break_reg <= break_reg - `UARTC_BRK_ONE;
    end

    // Break drives only once the character in flight is out
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            tx_break <= 1'b0;
        else if (!brk_req)
            tx_break <= 1'b0;
        else if (!tx_busy)
            tx_break <= 1'b1;
    end

    // =====================================================
    // Transmit and receive permissions to the engine
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_permit <= 1'b0;
            rx_accept <= 1'b0;
        end
        else
        begin
            tx_permit <= tx_on && !brk_req && !paused_reg
                && !(fmode == `UARTC_FLOW_HW && !cts_ok)
                && !(fmode == `UARTC_FLOW_MD_ALL && !addr_matched);
            rx_accept <= rx_gate;
        end
    end

    // =====================================================
    // Transceiver direction: drive, then hold delay bit times
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            xc_state_reg <= XC_IDLE;
            turn_cnt_reg <= 4'h0;
        end
        else
        begin
            case (xc_state_reg)
                XC_IDLE:
                    if (tx_busy)
                        xc_state_reg <= XC_DRIVE;
                XC_DRIVE:
                    if (!tx_busy)
                    begin
                        turn_cnt_reg <= delay_reg;
                        xc_state_reg <= (delay_reg == 4'h0) ? XC_IDLE : XC_HOLD;
                    end
                XC_HOLD:
                    if (tx_busy)
                        xc_state_reg <= XC_DRIVE;
                    else if (bit_tick)
                    begin
                        turn_cnt_reg <= turn_cnt_reg - 4'h1;
                        if (turn_cnt_reg == 4'h1)
                            xc_state_reg <= XC_IDLE;
                    end
                default:
                    xc_state_reg <= XC_IDLE;
            endcase
        end
    end

    // =====================================================
    // Pin function mapping
    wire rx_room = rx_on && !rx_fifo_full;
    wire pol = pin_func_reg[`UARTC_PF_POL];
    wire xc_drive = xc_active || tx_busy;
    reg [5:0] out_n;
    reg [5:0] oe_n;

    always @*
    begin
        out_n = 6'h00;
        oe_n = pin_dir_reg;
        case (pmode)
            `UARTC_PF_RTSCTS:
            begin
                oe_n[`UARTC_PIN_FOUR] = 1'b0;
                oe_n[`UARTC_PIN_FIVE] = 1'b1;
                out_n[`UARTC_PIN_FIVE] = !rx_room;
            end
            `UARTC_PF_DTRDSR:
            begin
                oe_n[`UARTC_PIN_TWO] = 1'b0;
                oe_n[`UARTC_PIN_THREE] = 1'b1;
                out_n[`UARTC_PIN_THREE] = !rx_room;
            end
            `UARTC_PF_XCVR_TX:
            begin
                oe_n[`UARTC_PIN_FIVE] = 1'b1;
                out_n[`UARTC_PIN_FIVE] = xc_drive ? pol : !pol;
            end
            `UARTC_PF_XCVR_MATCH:
            begin
                oe_n[`UARTC_PIN_FIVE] = 1'b1;
                out_n[`UARTC_PIN_FIVE] = (xc_drive && addr_matched) ? pol : !pol;
            end
            default:
                out_n = 6'h00;
        endcase
    end

    // Registered pin drivers
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_out <= 6'h00;
            pin_oe <= 6'h00;
        end
        else
        begin
            pin_out <= out_n;
            pin_oe <= oe_n;
        end
    end

endmodule

/* File: shared/uartc_regs.vh */
// Purpose: Register map, fields, resets and timing for the UART control block
// Assumes: 32-bit APB data, byte address is four times the register index
// Notes: Overview below lists the behaviour this block carries out
//
// Overview of operation
// - Class command copies shadows into working pin regs
// - Shadow registers load only from OTP port
// - Enable bit0 turns on TX, bit1 RX
// - Flow mode 0 none, 1 hardware, 2 software
// - Mode 3 gates receive on address match
// - Mode 4 gates both directions on match
// - Half-duplex bit drops receive while transmitting
// - Resume character restarts transmit, default 0x17
// - Pause character halts transmit, default 0x19
// - Sticky break, framing, parity, overrun; read clears
// - Byte arriving into full buffer flags overrun
// - Bit 7 shows live break on receive line
// - Break count 1..0xFFE decrements each millisecond
// - Rewriting count restarts decrement from new value
// - Count 0xFFF holds break until rewritten
// - Character in flight finishes before break starts
// - Break onset within 1 ms, end within 2 bits
// - Turn-around waits delay bit times before receive
// - Pin modes 000 GP, 001 CTS/RTS, 010 DSR/DTR
// - Modes 011/100 make pin five transceiver enable
// - Pin function bit 3 sets enable polarity
`ifndef UARTC_REGS_VH
`define UARTC_REGS_VH

// Register indices; byte address is index times four
`define UARTC_IDX_SH_FUNC 12'h217
`define UARTC_IDX_SH_DIR 12'h218
`define UARTC_IDX_SH_MASK 12'h219
`define UARTC_IDX_ENABLE 12'hc00
`define UARTC_IDX_FLOW 12'hc06
`define UARTC_IDX_RESUME 12'hc07
`define UARTC_IDX_PAUSE 12'hc08
`define UARTC_IDX_ERROR 12'hc09
`define UARTC_IDX_BREAK 12'hc0a
`define UARTC_IDX_DELAY 12'hc0b
`define UARTC_IDX_PIN_FUNC 12'hc0c
`define UARTC_IDX_PIN_DIR 12'hc0d
`define UARTC_IDX_PIN_MASK 12'hc11

// Field positions
`define UARTC_EN_TX 0
`define UARTC_EN_RX 1
`define UARTC_FLOW_HDX 3
`define UARTC_PF_POL 3
`define UARTC_ERR_BRK 3
`define UARTC_ERR_FRM 4
`define UARTC_ERR_PAR 5
`define UARTC_ERR_OVR 6
`define UARTC_ERR_LIVE 7

// Flow modes
`define UARTC_FLOW_NONE 3'h0
`define UARTC_FLOW_HW 3'h1
`define UARTC_FLOW_SW 3'h2
`define UARTC_FLOW_MD_RX 3'h3
`define UARTC_FLOW_MD_ALL 3'h4

// Pin function modes
`define UARTC_PF_GPIO 3'h0
`define UARTC_PF_RTSCTS 3'h1
`define UARTC_PF_DTRDSR 3'h2
`define UARTC_PF_XCVR_TX 3'h3
`define UARTC_PF_XCVR_MATCH 3'h4

// Pin numbers
`define UARTC_PIN_TWO 2
`define UARTC_PIN_THREE 3
`define UARTC_PIN_FOUR 4
`define UARTC_PIN_FIVE 5

// Reset values
`define UARTC_RST_RESUME 8'h17
`define UARTC_RST_PAUSE 8'h19
`define UARTC_RST_ZERO12 12'h000

// Break counter values
`define UARTC_BRK_HOLD 12'hfff
`define UARTC_BRK_ONE 12'h001
`define UARTC_BRK_ZERO 12'h000

// OTP shadow selects
`define UARTC_OTP_FUNC 2'h0
`define UARTC_OTP_DIR 2'h1
`define UARTC_OTP_MASK 2'h2

// Timing
`define UARTC_CLK_NS 40
`define UARTC_MS_NS 1000000
`define UARTC_MS_CYCLES (`UARTC_MS_NS / `UARTC_CLK_NS)

`endif

/* File: verif/uartc_line_model.sv */
// Purpose: Serial engine and remote line stand-in
// Assumes: Bit time of four clocks, ten bits a character
// Notes: Starts a character only when permitted and not in break
`timescale 1ns/100ps

module uartc_line_model (
    input wire clock,
    input wire reset_n,
    input wire send,
    input wire tx_permit,
    input wire tx_break,
    output reg bit_tick,
    output reg tx_busy
);
reg [1:0] div_reg;
reg [3:0] bits_reg;

// ==============================
// Bit timing and character shifting
always @(posedge clock or negedge reset_n)
begin
    if (!reset_n)
    begin
        div_reg <= 2'h0;
        bits_reg <= 4'h0;
        bit_tick <= 1'b0;
        tx_busy <= 1'b0;
    end
    else
    begin
        // Free-running tick so turn-around counts are real
        div_reg <= div_reg + 2'h1;
        bit_tick <= (div_reg == 2'h3);
        if (!tx_busy && send && tx_permit && !tx_break)
        begin
            tx_busy <= 1'b1;
            bits_reg <= 4'ha;
        end
        else if (tx_busy && bit_tick)
        begin
            bits_reg <= bits_reg - 4'h1;
            tx_busy <= (bits_reg != 4'h1);
        end
    end
end
endmodule

/* File: verif/uartc_props.sv */
// Purpose: Port checker for the UART control block
// Assumes: One clock, reset_n asynchronous and active low
// Notes: Bound into every uartc_top instance
`timescale 1ns/100ps
`include "uartc_regs.vh"

module uartc_props #(
    parameter MS_CYCLES = 20
) (
    input wire clock,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [13:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire tx_busy,
    input wire rx_break_level,
    input wire tx_permit,
    input wire tx_break
);
// ==============================
// Access decode
wire [11:0] idx = paddr[13:2];
wire brk_wr = pready && pwrite && (idx == `UARTC_IDX_BREAK);
wire err_rd = pready && !pwrite && (idx == `UARTC_IDX_ERROR);

default clocking @(posedge clock); endclocking
default disable iff (!reset_n);

// ==============================
// Bus handshake: exactly one wait state
chk_one_wait: assert property (psel && penable && !pready && !$past(penable) |=> pready)
    else $error("pready missing in second access cycle");
chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
chk_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
chk_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused access returned data");

// ==============================
// Error status and break generation
chk_live_break: assert property (err_rd |-> prdata[7] == $past(rx_break_level, 2))
    else $error("live break bit wrong");
chk_break_onset: assert property (brk_wr && pwdata[11:0] != 12'h0 ##0
    !tx_busy [*3] |-> tx_break)
    else $error("break did not start");
chk_break_stop: assert property (brk_wr && pwdata[11:0] == 12'h0 |-> ##2 !tx_break)
    else $error("break did not stop");
chk_break_waits: assert property ($rose(tx_break) |-> !$past(tx_busy))
    else $error("break cut a character");
chk_break_blocks: assert property (tx_break |-> !tx_permit)
    else $error("transmit permitted during break");
endmodule

bind uartc_top uartc_props #(.MS_CYCLES(MS_CYCLES)) i_props (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_busy(tx_busy),
    .rx_break_level(rx_break_level), .tx_permit(tx_permit), .tx_break(tx_break)
);

/* File: verif/uartc_top_test.sv */
// Purpose: Self-checking bench for the UART control block
// Assumes: Short millisecond count of MS cycles
// Notes: Register rows first, then gating, break and reset cases
`timescale 1ns/100ps
`include "uartc_regs.vh"

module uartc_top_test;
localparam MS = 20;
reg clock = 1'b0;
reg reset_n = 1'b0;
reg psel = 1'b0;
reg penable = 1'b0;
reg pwrite = 1'b0;
reg [13:0] paddr = 14'h0;
reg [31:0] pwdata = 32'h0;
reg otp_wr_valid = 1'b0;
reg [1:0] otp_wr_sel = 2'h0;
reg [11:0] otp_wr_data = 12'h0;
reg class_cmd = 1'b0;
reg rx_byte_valid = 1'b0;
reg [2:0] rx_flags = 3'h0;
reg rx_break_level = 1'b0;
reg addr_matched = 1'b0;
reg send = 1'b0;
reg [5:0] pin_in = 6'h0;
wire [31:0] prdata;
wire pready, pslverr, bit_tick, tx_busy, tx_permit, rx_accept, tx_break;
wire [5:0] pin_out, pin_oe;
integer fail_count = 0;
integer checks = 0;
integer i;
reg [31:0] rd;
reg err;
reg [41:0] rows [0:13];
reg [9:0] gate [0:10];

always #20 clock = ~clock;

uartc_top #(.MS_CYCLES(MS)) i_dut (.clock(clock), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .otp_wr_valid(otp_wr_valid),
    .otp_wr_sel(otp_wr_sel), .otp_wr_data(otp_wr_data), .class_cmd(class_cmd),
    .bit_tick(bit_tick), .tx_busy(tx_busy), .rx_byte_valid(rx_byte_valid),
    .rx_byte(8'h5a), .rx_frame_err(rx_flags[0]), .rx_parity_err(rx_flags[1]),
    .rx_fifo_full(rx_flags[2]), .rx_break_level(rx_break_level),
    .addr_matched(addr_matched), .tx_permit(tx_permit), .rx_accept(rx_accept),
    .tx_break(tx_break), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

uartc_line_model i_line (.clock(clock), .reset_n(reset_n), .send(send),
    .tx_permit(tx_permit), .tx_break(tx_break), .bit_tick(bit_tick), .tx_busy(tx_busy));

// ==============================
// Shared tasks
task report_and_stop;
begin
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
end
endtask

task check(input [31:0] got, input [31:0] exp);
begin
    checks = checks + 1;
    if (got !== exp)
    begin
        fail_count = fail_count + 1;
        $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
end
endtask

task cyc(input integer n);
begin
    repeat (n) @(posedge clock);
end
endtask

// Holds the request until pready, bounded so a dead slave cannot hang us
task apb(input w, input [11:0] idx, input [31:0] d);
    integer n;
begin
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    @(posedge clock);
    while (pready !== 1'b1 && n < 8)
    begin
        n = n + 1;
        @(posedge clock);
    end
    if (n == 8)
    begin
        fail_count = fail_count + 1;
        report_and_stop;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
end
endtask

// Host keeps the UART off while it reconfigures
task setup(input [11:0] flow, input [11:0] en);
begin
    apb(1'b1, `UARTC_IDX_ENABLE, 32'h0);
    apb(1'b1, `UARTC_IDX_FLOW, {20'h0, flow});
    apb(1'b1, `UARTC_IDX_ENABLE, {20'h0, en});
    cyc(2);
end
endtask

task rx(input [2:0] f);
begin
    @(posedge clock);
    rx_byte_valid <= 1'b1;
    rx_flags <= f;
    @(posedge clock);
    rx_byte_valid <= 1'b0;
    rx_flags <= 3'h0;
    cyc(2);
end
endtask

task wait_busy(input v);
    integer n;
begin
    n = 0;
    while (tx_busy !== v && n < 200)
    begin
        n = n + 1;
        @(posedge clock);
    end
    if (n == 200)
    begin
        fail_count = fail_count + 1;
        report_and_stop;
    end
end
endtask

// ==============================
// Main sequence
initial
begin
    // Register rows: index, write, read-back, expected pin drive
    rows[0] = {`UARTC_IDX_RESUME, 12'h0a5, 12'h0a5, 6'h00};
    rows[1] = {`UARTC_IDX_PAUSE, 12'h05a, 12'h05a, 6'h00};
    rows[2] = {`UARTC_IDX_DELAY, 12'h00f, 12'h00f, 6'h00};
    rows[3] = {`UARTC_IDX_FLOW, 12'h00c, 12'h00c, 6'h00};
    rows[4] = {`UARTC_IDX_FLOW, 12'h000, 12'h000, 6'h00};
    rows[5] = {`UARTC_IDX_PIN_MASK, 12'h02a, 12'h02a, 6'h00};
    rows[6] = {`UARTC_IDX_PIN_DIR, 12'h015, 12'h015, 6'h15};
    rows[7] = {`UARTC_IDX_PIN_DIR, 12'h000, 12'h000, 6'h00};
    rows[8] = {`UARTC_IDX_PIN_FUNC, 12'h001, 12'h001, 6'h20};
    rows[9] = {`UARTC_IDX_PIN_FUNC, 12'h002, 12'h002, 6'h08};
    rows[10] = {`UARTC_IDX_PIN_FUNC, 12'h003, 12'h003, 6'h20};
    rows[11] = {`UARTC_IDX_PIN_FUNC, 12'h00c, 12'h00c, 6'h20};
    rows[12] = {`UARTC_IDX_PIN_FUNC, 12'h000, 12'h000, 6'h00};
    rows[13] = {`UARTC_IDX_ERROR, 12'h0f8, 12'h000, 6'h00};
    // Gating rows: flow, enables, match, clear-to-send level, tx/rx
    gate[0] = {4'h0, 2'b01, 2'b00, 2'b10};
    gate[1] = {4'h0, 2'b10, 2'b00, 2'b01};
    gate[2] = {4'h0, 2'b11, 2'b00, 2'b11};
    gate[3] = {4'h3, 2'b11, 2'b00, 2'b10};
    gate[4] = {4'h3, 2'b11, 2'b10, 2'b11};
    gate[5] = {4'h4, 2'b11, 2'b00, 2'b00};
    gate[6] = {4'h4, 2'b11, 2'b10, 2'b11};
    gate[7] = {4'h1, 2'b11, 2'b01, 2'b01};
    gate[8] = {4'h1, 2'b11, 2'b00, 2'b11};
    gate[9] = {4'h2, 2'b11, 2'b00, 2'b11};
    gate[10] = {4'h0, 2'b00, 2'b00, 2'b00};
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    apb(1'b0, `UARTC_IDX_RESUME, 32'h0);
    check(rd, 32'h17);
    apb(1'b0, `UARTC_IDX_PAUSE, 32'h0);
    check(rd, 32'h19);
    for (i = 0; i < 14; i = i + 1)
    begin
        apb(1'b1, rows[i][41:30], {20'h0, rows[i][29:18]});
        apb(1'b0, rows[i][41:30], 32'h0);
        check(rd, {20'h0, rows[i][17:6]});
        cyc(1);
        check({26'h0, pin_oe}, {26'h0, rows[i][5:0]});
    end
    $display("register rows done");
    apb(1'b0, 12'hc01, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // Pin 4 as clear-to-send for the hardware flow rows
    apb(1'b1, `UARTC_IDX_PIN_FUNC, 32'h1);
    for (i = 0; i < 11; i = i + 1)
    begin
        addr_matched <= gate[i][3];
        pin_in <= {1'b0, gate[i][2], 4'h0};
        setup({8'h0, gate[i][9:6]}, {10'h0, gate[i][5:4]});
        check({tx_permit, rx_accept}, gate[i][1:0]);
    end
    setup(12'h001, 12'h002);
    check(pin_out[5], 1'b0);
    rx_flags <= 3'h4;
    cyc(3);
    check(pin_out[5], 1'b1);
    rx_flags <= 3'h0;
    $display("gating rows done");
    // Shadows load only from OTP and apply on the class command
    apb(1'b1, `UARTC_IDX_ENABLE, 32'h0);
    @(posedge clock);
    otp_wr_valid <= 1'b1;
    otp_wr_data <= 12'h00a;
    @(posedge clock);
    otp_wr_sel <= `UARTC_OTP_DIR;
    otp_wr_data <= 12'h03f;
    @(posedge clock);
    otp_wr_valid <= 1'b0;
    apb(1'b1, `UARTC_IDX_SH_FUNC, 32'h5);
    apb(1'b0, `UARTC_IDX_PIN_FUNC, 32'h0);
    check(rd, 32'h1);
    @(posedge clock);
    class_cmd <= 1'b1;
    @(posedge clock);
    class_cmd <= 1'b0;
    apb(1'b0, `UARTC_IDX_PIN_FUNC, 32'h0);
    check(rd, 32'ha);
    check({26'h0, pin_oe}, 32'h3b);
    apb(1'b1, `UARTC_IDX_PIN_DIR, 32'h0);
    $display("shadow test done");
    // Software flow: characters change only while the UART is off
    apb(1'b1, `UARTC_IDX_PAUSE, 32'h5a);
    setup(12'h002, 12'h003);
    rx(3'h0);
    check(tx_permit, 1'b0);
    apb(1'b1, `UARTC_IDX_ENABLE, 32'h0);
    apb(1'b1, `UARTC_IDX_PAUSE, 32'h19);
    apb(1'b1, `UARTC_IDX_RESUME, 32'h5a);
    apb(1'b1, `UARTC_IDX_ENABLE, 32'h3);
    cyc(2);
    check(tx_permit, 1'b0);
    rx(3'h0);
    check(tx_permit, 1'b1);
    // Sticky flags one at a time, each cleared by the read
    for (i = 0; i < 3; i = i + 1)
    begin
        rx(3'h1 << i);
        apb(1'b0, `UARTC_IDX_ERROR, 32'h0);
        check(rd & 32'hf8, 32'h10 << i);
    end
    rx_break_level <= 1'b1;
    cyc(2);
    apb(1'b0, `UARTC_IDX_ERROR, 32'h0);
    check(rd & 32'hf8, 32'h88);
    rx_break_level <= 1'b0;
    cyc(2);
    apb(1'b0, `UARTC_IDX_ERROR, 32'h0);
    check(rd & 32'hf8, 32'h0);
    $display("flow and error tests done");
    // Half duplex, turn-around and break behind a character
    setup(12'h000, 12'h000);
    apb(1'b1, `UARTC_IDX_PIN_FUNC, 32'h3);
    apb(1'b1, `UARTC_IDX_DELAY, 32'h2);
    setup(12'h008, 12'h003);
    @(posedge clock);
    send <= 1'b1;
    @(posedge clock);
    send <= 1'b0;
    wait_busy(1'b1);
    apb(1'b1, `UARTC_IDX_BREAK, 32'h2);
    check({rx_accept, pin_out[5], tx_break}, 3'b000);
    wait_busy(1'b0);
    cyc(2);
    check({pin_out[5], tx_break}, 2'b01);
    cyc(12);
    check({pin_out[5], rx_accept}, 2'b11);
    cyc(3 * MS + 6);
    check(tx_break, 1'b0);
    apb(1'b1, `UARTC_IDX_BREAK, 32'hfff);
    cyc(5 * MS);
    check(tx_break, 1'b1);
    apb(1'b1, `UARTC_IDX_BREAK, 32'h3);
    cyc(MS);
    check(tx_break, 1'b1);
    apb(1'b1, `UARTC_IDX_BREAK, 32'h0);
    cyc(2);
    check(tx_break, 1'b0);
    apb(1'b1, `UARTC_IDX_BREAK, 32'hfff);
    $display("break tests done");
    // Second reset in mid-break
    @(posedge clock);
    reset_n <= 1'b0;
    cyc(2);
    check({tx_break, pin_oe}, 7'h0);
    reset_n <= 1'b1;
    apb(1'b0, `UARTC_IDX_RESUME, 32'h0);
    check(rd, 32'h17);
    $display("reset test done");
    report_and_stop;
end
endmodule
